// ===== hdl/ee2w_pkg.sv
// Purpose: shared constants of the two-wire EEPROM slave and its master
// Assumes: one clock pclk at 25 MHz
// Notes: the control code value is arbitrary
package ee2w_pkg;
  // Timing
  localparam int CLK_NS = 40;
  localparam int WC_NS = 5000000;
  localparam int WC_CYC = WC_NS / CLK_NS;
  // Device addressing
  localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value
  localparam int MEM_BYTES = 2048;
  localparam int PAGE_BYTES = 16;
  // Master register offsets
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] DIV_OFF = 8'h08;
  // Command fields
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_NACK = 3;
  localparam int CMD_DATA = 8;
  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_DATA = 8;
  // Quarter-bit divider and acknowledge bit number
  localparam logic [15:0] DIV_RST = 16'h0005;
  localparam logic [15:0] DIV_MIN = 16'h0004;
  localparam logic [3:0] ACK_BIT = 4'h8;
endpackage

// ===== hdl/ee2w_if.sv
// Purpose: two-wire bus carrier joining master and slave
// Assumes: pull-up gives high when nobody pulls low
// Notes: scl is driven by the master only
`timescale 1ns/1ps
interface ee2w_if;
  logic scl; // Serial clock from master
  logic m_sda_o; // Master data out
  logic m_sda_oe; // Master drives data
  logic s_sda_o; // Slave data out
  logic s_sda_oe; // Slave drives data
  logic sda; // Resolved line level
  // Wired-and with pull-up
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ===== hdl/ee2w_cond.sv
// Purpose: synchronise bus lines, find edges and bus conditions
// Assumes: lines are asynchronous to pclk
// Notes: edge logic reads only second and third stages
`timescale 1ns/1ps
module ee2w_cond import ee2w_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Synchronised view
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  typedef struct packed {
    logic [1:0] s1; // First stage {scl,sda}
    logic [1:0] s2; // Second stage
    logic [1:0] s3; // Previous sample for edges
  } ee2w_cst_t;
  ee2w_cst_t c_reg, c_next;

  // Shift chain
  always_comb begin
    c_next = c_reg;
    c_next.s1 = {scl_i, sda_i};
    c_next.s2 = c_reg.s1;
    c_next.s3 = c_reg.s2;
  end

  // Lines idle high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c_reg <= '1;
    else c_reg <= c_next;
  end

  assign scl_s = c_reg.s2[1];
  assign sda_s = c_reg.s2[0];
  assign scl_rise = c_reg.s2[1] && !c_reg.s3[1];
  assign scl_fall = !c_reg.s2[1] && c_reg.s3[1];
  // Data moving while clock high is a condition
  assign start_det = c_reg.s2[1] && c_reg.s3[1] && !c_reg.s2[0] && c_reg.s3[0];
  assign stop_det = c_reg.s2[1] && c_reg.s3[1] && c_reg.s2[0] && !c_reg.s3[0];
endmodule // ee2w_cond

// ===== hdl/ee2w_slave.sv
// Purpose: EEPROM end of the two-wire link with array and page buffer
// Assumes: master keeps at least four pclk per clock phase
// Notes: array is flip-flops; programming time is a parameter
`timescale 1ns/1ps
module ee2w_slave import ee2w_pkg::*; #(
  parameter int WC_CYCLES = WC_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Two-wire bus
  ee2w_if.slave bus,
  // Straps
  input wire logic wp,
  input wire logic unused_address_pin_0,
  input wire logic unused_address_pin_1,
  input wire logic unused_address_pin_2,
  // Status
  output logic write_busy
);
  // Refuse a timer that cannot count
  if (WC_CYCLES < 1 || WC_CYCLES > 32'h00ffffff) begin : g_bad_wc
    $error("WC_CYCLES out of range");
  end

  // Bus phase of the slave
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} ee2w_sst_t;

  typedef struct packed {
    ee2w_sst_t st; // Bus phase
    logic [3:0] cnt; // Bits moved in this byte
    logic [7:0] sh; // Shift register
    logic [1:0] bidx; // 0 control, 1 address, 2 data
    logic rw; // Direction from control byte
    logic [2:0] blk; // Block select
    logic [10:0] ptr; // Address pointer
    logic [PAGE_BYTES-1:0][7:0] pbuf; // Page buffer
    logic [PAGE_BYTES-1:0] pmask; // Bytes loaded in buffer
    logic wpend; // Data waits for stop
    logic busy; // Programming in progress
    logic [23:0] tmr; // Programming countdown
    logic mack; // Master acknowledged last byte
    logic oe; // Pulling data low
    logic [1:0] wps; // Write protect synchroniser
    logic [MEM_BYTES-1:0][7:0] mem; // Array
  } ee2w_sl_t;
  ee2w_sl_t s_reg, s_next;

  // Synchronised bus view
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  ee2w_cond u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // Fetch the byte at the pointer and present its top bit
  function automatic ee2w_sl_t tx_load(input ee2w_sl_t s);
    ee2w_sl_t t;
    t = s;
    t.sh = s.mem[s.ptr];
    t.oe = !s.mem[s.ptr][7];
    t.ptr = s.ptr + 11'd1;
    t.cnt = 4'd1;
    t.st = S_TX;
    return t;
  endfunction

  // Whole next-state computation
  always_comb begin
    s_next = s_reg;
    // Write protect is a pin, synchronise it
    s_next.wps = {s_reg.wps[0], wp};

    // Self-timed programming of one page
    if (s_reg.busy) begin
      s_next.tmr = s_reg.tmr - 24'd1;
      if (s_reg.tmr == 24'd1) begin
        s_next.busy = 1'b0;
        // Only loaded bytes are written; untouched bytes keep their old value
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (s_reg.pmask[i]) begin
            s_next.mem[{s_reg.ptr[10:4], i[3:0]}] = s_reg.pbuf[i];
          end
        end
      end
    end

    if (start_det) begin
      // Restart from the control byte anywhere
      s_next.st = S_RX;
      s_next.cnt = 4'd0;
      s_next.bidx = 2'd0;
      s_next.oe = 1'b0;
      // Buffered data without a stop is dropped
      s_next.wpend = 1'b0;
    end else if (stop_det) begin
      // Stop ends the transaction
      if (s_reg.wpend && !s_reg.wps[1]) begin
        s_next.busy = 1'b1;
        s_next.tmr = WC_CYCLES[23:0];
      end
      s_next.wpend = 1'b0;
      s_next.oe = 1'b0;
      s_next.st = S_IDLE;
    end else begin
      case (s_reg.st)
        // Wait for a start, line released
        S_IDLE: begin
          s_next.oe = 1'b0;
        end
        // Take one bit per clock rise
        S_RX: begin
          if (scl_rise && s_reg.cnt != 4'd8) begin
            s_next.sh = {s_reg.sh[6:0], sda_s};
            s_next.cnt = s_reg.cnt + 4'd1;
          end else if (scl_fall && s_reg.cnt == 4'd8) begin
            if (s_reg.busy) begin
              // No acknowledge while programming
              s_next.st = S_IDLE;
            end else if (s_reg.bidx == 2'd0 && s_reg.sh[7:4] != TYPE_CODE) begin
              // Not for us: stay silent
              s_next.st = S_IDLE;
            end else begin
              // Pull low for the ninth clock
              s_next.oe = 1'b1;
              s_next.st = S_ACK;
              case (s_reg.bidx)
                // Control byte
                2'd0: begin
                  s_next.rw = s_reg.sh[0];
                  s_next.blk = s_reg.sh[3:1];
                  s_next.bidx = 2'd1;
                end
                // Word address byte
                2'd1: begin
                  s_next.ptr = {s_reg.blk, s_reg.sh};
                  s_next.pmask = '0;
                  s_next.bidx = 2'd2;
                end
                // Data bytes into the page buffer
                default: begin
                  s_next.pbuf[s_reg.ptr[3:0]] = s_reg.sh;
                  s_next.pmask[s_reg.ptr[3:0]] = 1'b1;
                  s_next.ptr[3:0] = s_reg.ptr[3:0] + 4'd1;
                  s_next.wpend = 1'b1;
                end
              endcase
            end
          end
        end
        // Hold low until the ninth clock falls
        S_ACK: begin
          if (scl_fall) begin
            if (s_reg.rw && s_reg.bidx == 2'd1) begin
              s_next = tx_load(s_next);
            end else begin
              s_next.oe = 1'b0;
              s_next.cnt = 4'd0;
              s_next.st = S_RX;
            end
          end
        end
        // Change data only after a clock fall
        S_TX: begin
          if (scl_fall) begin
            if (s_reg.cnt == 4'd8) begin
              s_next.oe = 1'b0;
              s_next.st = S_TXACK;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.oe = !s_reg.sh[6];
              s_next.cnt = s_reg.cnt + 4'd1;
            end
          end
        end
        // Master answers the byte
        S_TXACK: begin
          if (scl_rise) begin
            s_next.mack = !sda_s;
          end else if (scl_fall) begin
            if (s_reg.mack) begin
              s_next = tx_load(s_next);
            end else begin
              // Released, master may now stop
              s_next.oe = 1'b0;
              s_next.st = S_IDLE;
            end
          end
        end
        default: begin
          s_next.st = S_IDLE;
          s_next.oe = 1'b0;
        end
      endcase
    end
  end

  // Single state register; array clears to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  // Open drain: only ever pull low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = s_reg.oe;
  assign write_busy = s_reg.busy;
endmodule // ee2w_slave

// ===== hdl/ee2w_master.sv
// Purpose: two-wire master steered by APB registers
// Assumes: bus idle high at reset; one slave
// Notes: each bit spends four divider quarters
`timescale 1ns/1ps
module ee2w_master import ee2w_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire bus
  ee2w_if.master bus
);
  // Sequencer phase
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} ee2w_mst_t;

  typedef struct packed {
    ee2w_mst_t st; // Sequencer
    logic [1:0] ph; // Quarter within step
    logic [15:0] qcnt; // Quarter countdown
    logic [15:0] div; // Quarter length
    logic [3:0] cnt; // Bit number
    logic [7:0] tx; // Byte to send
    logic [7:0] rx; // Byte received
    logic rd; // Read byte
    logic nack; // Withhold acknowledge
    logic dostop; // Stop after byte
    logic ack; // Slave acknowledged
    logic scl; // Clock out
    logic oe; // Pulling data low
    logic [31:0] prdata; // Read data
  } ee2w_ms_t;
  ee2w_ms_t m_reg, m_next;

  logic sda_s; // Synchronised data line
  logic qtick; // Quarter enable pulse

  ee2w_cond u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(m_reg.scl),
    .sda_i(bus.sda),
    .scl_s(),
    .sda_s(sda_s),
    .scl_rise(),
    .scl_fall(),
    .start_det(),
    .stop_det()
  );

  // Offset decode, used by the error only
  function automatic logic addr_ok(input logic [7:0] a);
    return a == CMD_OFF || a == STAT_OFF || a == DIV_OFF;
  endfunction

  assign qtick = m_reg.st != M_IDLE && m_reg.qcnt == 16'h0000;

  // Whole next-state computation
  always_comb begin
    m_next = m_reg;
    if (m_reg.st != M_IDLE) m_next.qcnt = m_reg.qcnt - 16'h0001;

    // Read data latched in setup
    if (psel && !penable) begin
      m_next.prdata = '0;
      if (paddr == STAT_OFF) begin
        m_next.prdata[STAT_BUSY] = m_reg.st != M_IDLE;
        m_next.prdata[STAT_ACK] = m_reg.ack;
        m_next.prdata[STAT_DATA +: 8] = m_reg.rx;
      end else if (paddr == DIV_OFF) begin
        m_next.prdata[15:0] = m_reg.div;
      end
    end

    // Writes act in the access phase
    if (psel && penable && pwrite) begin
      if (paddr == CMD_OFF && m_reg.st == M_IDLE) begin
        // Master alone decides direction and framing
        m_next.tx = pwdata[CMD_DATA +: 8];
        m_next.rd = pwdata[CMD_READ];
        m_next.nack = pwdata[CMD_NACK];
        m_next.dostop = pwdata[CMD_STOP];
        m_next.st = pwdata[CMD_START] ? M_START : M_BIT;
        m_next.ph = 2'd0;
        m_next.cnt = 4'd0;
        m_next.qcnt = m_reg.div - 16'h0001;
      end else if (paddr == DIV_OFF && pwdata[15:0] >= DIV_MIN) begin
        // Too short a quarter would outrun the synchronisers
        m_next.div = pwdata[15:0];
      end
    end

    // One quarter step per enable
    if (qtick) begin
      m_next.qcnt = m_reg.div - 16'h0001;
      m_next.ph = m_reg.ph + 2'd1;
      case (m_reg.st)
        // Release, clock high, data low, clock low
        M_START: begin
          case (m_reg.ph)
            2'd0: m_next.oe = 1'b0;
            2'd1: m_next.scl = 1'b1;
            2'd2: m_next.oe = 1'b1;
            default: begin
              m_next.scl = 1'b0;
              m_next.st = M_BIT;
            end
          endcase
        end
        // Data set in low phase, sampled in high phase
        M_BIT: begin
          case (m_reg.ph)
            2'd0: begin
              if (m_reg.cnt == ACK_BIT) m_next.oe = m_reg.rd && !m_reg.nack;
              else m_next.oe = !m_reg.rd && !m_reg.tx[3'd7 - m_reg.cnt[2:0]];
            end
            2'd1: m_next.scl = 1'b1;
            2'd2: begin
              if (m_reg.cnt == ACK_BIT) m_next.ack = !sda_s;
              else m_next.rx = {m_reg.rx[6:0], sda_s};
            end
            default: begin
              m_next.scl = 1'b0;
              if (m_reg.cnt == ACK_BIT) begin
                m_next.oe = 1'b0;
                m_next.st = m_reg.dostop ? M_STOP : M_IDLE;
              end else begin
                m_next.cnt = m_reg.cnt + 4'd1;
              end
            end
          endcase
        end
        // Data low, clock high, data released
        M_STOP: begin
          case (m_reg.ph)
            2'd0: m_next.oe = 1'b1;
            2'd1: m_next.scl = 1'b1;
            2'd2: m_next.oe = 1'b0;
            default: m_next.st = M_IDLE;
          endcase
        end
        default: m_next.st = M_IDLE;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_reg <= '0;
      m_reg.scl <= 1'b1;
      m_reg.div <= DIV_RST;
    end else begin
      m_reg <= m_next;
    end
  end

  // Zero-wait slave, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = m_reg.prdata;
  assign bus.scl = m_reg.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = m_reg.oe;
endmodule // ee2w_master

// ===== bench/ee2w_link_sva.sv
// Purpose: wire-level checks on the two-wire link between master and slave
// Assumes: divider quarter of at least four pclk
// Notes: sees only the carrier signals, so it judges both ends at once
`timescale 1ns/1ps
module ee2w_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Carrier lines
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic sda
);
  // One domain, so clock and reset are given once
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Slave may only pull low
  a_slave_open_drain: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave drives data high");
  // Start holds the clock high a while, so the slave can see it
  a_start_hold: assert property ($rose(m_sda_oe) && scl |=> scl [*3])
    else $error("start not held");
  // Start only from an idle bus
  a_idle_start: assert property ($rose(m_sda_oe) && scl |-> $past(sda) && $past(scl))
    else $error("start on busy bus");
  // Stop leaves both lines high
  a_stop_form: assert property ($fell(m_sda_oe) && scl |=> (scl && sda) [*3])
    else $error("stop not followed by idle");
  // Clock high phase lasts at least eight pclk
  a_pulse_len: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  // Master data settled before and early in the high phase
  a_bit_stable: assert property ($rose(scl) |-> $stable(m_sda_oe) [*4])
    else $error("master data moved with clock high");
  // Slave data changes only while the clock is low
  a_slave_still: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data moved with clock high");
  // Whatever the slave pulls stays low through the high phase
  a_ack_low: assert property ($rose(scl) && s_sda_oe |-> !sda [*8])
    else $error("slave low not held");
  // After a stop the slave stays off the line
  a_stop_quiet: assert property ($rose(sda) && scl |=> !s_sda_oe [*8])
    else $error("slave drives after stop");
  // Main scenarios seen
  c_start: cover property ($rose(m_sda_oe) && scl);
  c_slave_ack: cover property ($rose(scl) && s_sda_oe);
  c_stop: cover property ($fell(m_sda_oe) && scl);
endmodule // ee2w_link_sva

// ===== bench/ee2w_test.sv
// Purpose: self-checking bench for the two-wire master and EEPROM slave
// Assumes: programming time shortened to 400 pclk
// Notes: expected array and pointer live in a bench model
`timescale 1ns/1ps
module ee2w_test import ee2w_pkg::*; ;
  localparam int WC_T = 400; // Short, but longer than one poll
  // APB side
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Slave straps and status
  logic wp = 1'b0;
  logic [2:0] apin = 3'h0; // Ignored straps, driven random
  logic write_busy;
  // Score and model
  int errors = 0;
  int checks_done = 0;
  logic [7:0] mem [MEM_BYTES]; // Expected array
  logic [10:0] ptr = 11'h000; // Expected pointer
  logic [31:0] st; // Last status word
  ee2w_if i_ee2w_if ();
  ee2w_master i_ee2w_master (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(i_ee2w_if.master));
  ee2w_slave #(.WC_CYCLES(WC_T)) i_ee2w_slave (.pclk(pclk), .presetn(presetn),
    .bus(i_ee2w_if.slave), .wp(wp), .unused_address_pin_0(apin[0]),
    .unused_address_pin_1(apin[1]), .unused_address_pin_2(apin[2]), .write_busy(write_busy));
  ee2w_link_sva i_ee2w_link_sva (.pclk(pclk), .presetn(presetn), .scl(i_ee2w_if.scl),
    .m_sda_o(i_ee2w_if.m_sda_o), .m_sda_oe(i_ee2w_if.m_sda_oe), .s_sda_o(i_ee2w_if.s_sda_o),
    .s_sda_oe(i_ee2w_if.s_sda_oe), .sda(i_ee2w_if.sda));
  // Free-running clock
  always #20 pclk = ~pclk;
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count of its own; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One link step: flags are nack, read, stop, start from bit 3 down
  task automatic xfer(input logic [3:0] f, input logic [7:0] tx);
    logic [31:0] q;
    logic e;
    apb(1'b1, CMD_OFF, {16'h0, tx, 4'h0, f}, q, e);
    repeat (2) @(posedge pclk); // Busy shows from the edge that ends the write
    // Poll until idle; a stuck sequencer is caught by the watchdog
    do begin
      apb(1'b0, STAT_OFF, 32'h0, st, e);
    end while (st[STAT_BUSY] !== 1'b0);
  endtask
  // Load the pointer with a write header, no stop
  task automatic set_ptr(input logic [10:0] a);
    xfer(4'h1, {TYPE_CODE, a[10:8], 1'b0});
    check("control ack", 8'(st[STAT_ACK]), 8'h01);
    xfer(4'h0, a[7:0]);
    check("address ack", 8'(st[STAT_ACK]), 8'h01);
    ptr = a;
  endtask
  // Next location inside the same page: only the low four bits step
  function automatic logic [10:0] page_next(input logic [10:0] a);
    return {a[10:4], 4'(a[3:0] + 4'h1)};
  endfunction
  // Write n random bytes from a, stop, poll while programming
  task automatic wr(input logic [10:0] a, input int n);
    logic [7:0] d;
    logic [10:0] p;
    set_ptr(a);
    p = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      xfer((i == n - 1) ? 4'h2 : 4'h0, d);
      check("data ack", 8'(st[STAT_ACK]), 8'h01);
      if (wp === 1'b0) mem[p] = d;
      p = page_next(p);
    end
    ptr = p;
    check("write busy", 8'(write_busy), 8'(!wp));
    xfer(4'h3, {TYPE_CODE, 3'h0, 1'b0});
    check("poll ack", 8'(st[STAT_ACK]), 8'(wp));
    // Wait out programming; the watchdog ends a cycle that never finishes
    while (write_busy !== 1'b0) @(posedge pclk);
  endtask
  // Read n bytes at the pointer, refuse the last and stop
  task automatic rd(input int n);
    xfer(4'h1, {TYPE_CODE, 3'h0, 1'b1});
    check("read ack", 8'(st[STAT_ACK]), 8'h01);
    for (int i = 0; i < n; i++) begin
      xfer((i == n - 1) ? 4'he : 4'h4, 8'h00);
      check("read data", st[STAT_DATA +: 8], mem[ptr]);
      ptr++;
    end
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    errors++;
    $display("watchdog expired");
    end_sim();
  end
  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    logic [10:0] a;
    void'($urandom(86));
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Registers: divider floor and unmapped word
    apb(1'b1, DIV_OFF, 32'h3, q, e);
    apb(1'b0, DIV_OFF, 32'h0, q, e);
    check("divider", q[7:0], DIV_RST[7:0]);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check("unmapped error", 8'(e), 8'h01);
    check("unmapped data", q[7:0], 8'h00);
    $display("test registers done");
    // Byte write, random read with restart, current-address read
    a = 11'($urandom);
    apin <= 3'($urandom);
    wr(a, 1);
    set_ptr(a);
    rd(2);
    rd(1);
    $display("test byte write done");
    // Foreign type code: no ack, rest ignored, nothing written
    xfer(4'h1, {~TYPE_CODE, 4'h0});
    check("foreign ack", 8'(st[STAT_ACK]), 8'h00);
    xfer(4'h2, 8'h55);
    check("ignored ack", 8'(st[STAT_ACK]), 8'h00);
    check("no write", 8'(write_busy), 8'h00);
    $display("test foreign code done");
    // Protected write leaves the array as it was
    wp <= 1'b1;
    wr(a, 2);
    set_ptr(a);
    rd(2);
    wp <= 1'b0;
    $display("test protect done");
    // Page writes: overrun corner first, then random lengths
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? {7'($urandom), 4'he} : 11'($urandom);
      apin <= 3'($urandom);
      wr(a, (k == 0) ? 18 : 1 + int'($urandom % 20));
      set_ptr({a[10:4], 4'h0});
      rd(16);
      $display("test page %0d done", k);
    end
    end_sim();
  end
endmodule // ee2w_test
